// ### design/tcact_core.sv
// Control, error stop, vector base and activation sequencer of the transfer controller
// Contract
// - Repeat mode reloads low counter at zero
// - Chain enable clear: no chain at reload
// - Chain enable set: chain at reload
// - Control bits 2 and 1 read zero
// - Address error or NMI halts, sets stop
// - Stop clears by writing 0 after 1
// - Vector base register is 32 bits
// - Vector base writable only in 27..12
// - Vector base resets to zero
// - Only enabled interrupt requests start transfers
// - Transfer end clears flag or enable; a vector base write in the end cycle suppresses the flag clear
// - Read skip on same vector, unless chained
// - Enable stays when select 0, count left
// - Fetch vector entry, then transfer information
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module tcact_core
	import tcact_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [31:0] reg_rdata_o,
	input wire logic [15:0] irq_i,
	input wire logic nmi_i,
	output logic [15:0] cpu_irq_o,
	output logic [15:0] flag_clr_o,
	output logic bus_req_o,
	output logic bus_we_o,
	output logic [31:0] bus_addr_o,
	output logic [31:0] bus_wdata_o,
	input wire logic [31:0] bus_rdata_i,
	input wire logic bus_ack_i,
	input wire logic bus_addr_err_i
);
	// ==========================================
	// Declarations
	tcact_state_t state_q;
	logic err_q, err_armed_q, chain_en_q, skip_en_q;
	logic [15:0] vbase_q, src_en_q, cpu_irq_q, flag_clr_q;
	logic [31:0] rdata_q, addr_q, wdata_q, info_q, w0_q, sar_q, dar_q;
	logic req_q, we_q, end_q, chained_q, last_chain_q, cache_ok_q, reloaded_q;
	logic [3:0] src_q, last_src_q, pick_idx;
	logic pick_vld, abort, start, skip, chain_go, clr_en, err_clr;
	logic [7:0] low_cnt, low_dec, hi_cnt;
	logic [31:0] w0_next;

	// Entry address of one source in the vector table
	function automatic logic [31:0] entry_addr(input logic [15:0] vb, input logic [3:0] idx);
		entry_addr = {4'h0, vb, 12'h000} + TCACT_VEC_OFS0
			+ TCACT_ENTRY_BYTES * {28'h0000000, 4'(4'hF - idx)};
	endfunction : entry_addr

	// ==========================================
	// Request routing: enabled sources go to the sequencer, the rest to the CPU
	tcact_pick u_pick (
		.req_i(irq_i & src_en_q),
		.valid_o(pick_vld),
		.idx_o(pick_idx)
	);

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			cpu_irq_q <= 16'h0000;
		else
			cpu_irq_q <= irq_i & ~src_en_q;
	end

	// One idle cycle after an end gives the source time to drop its request
	assign start = (state_q == TCACT_IDLE) && pick_vld && !err_q && !end_q && !nmi_i;
	assign skip = skip_en_q && cache_ok_q && !last_chain_q && (pick_idx == last_src_q);
	assign abort = nmi_i || (req_q && bus_addr_err_i);

	// ==========================================
	// Counter update on each completed data transfer
	assign low_cnt = w0_q[7:0];
	assign hi_cnt = w0_q[TCACT_W0_HI_LSB +: 8];
	assign low_dec = low_cnt - TCACT_CNT_ONE;
	always_comb
	begin
		w0_next = w0_q;
		if (w0_q[TCACT_W0_REPEAT] && low_dec == TCACT_CNT_ZERO)
			w0_next[7:0] = hi_cnt;
		else
			w0_next[7:0] = low_dec;
	end

	// Chain after a reload only when the enable permits it
	assign chain_go = w0_q[TCACT_W0_CHAIN] && (!reloaded_q || chain_en_q);
	// Enable cleared when select is set or a normal count ran out
	assign clr_en = w0_q[TCACT_W0_SELECT]
		|| (!w0_q[TCACT_W0_REPEAT] && low_cnt == TCACT_CNT_ZERO);

	// ==========================================
	// Sequencer and system bus master
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q <= TCACT_IDLE;
			req_q <= 1'b0;
			we_q <= 1'b0;
			addr_q <= 32'h00000000;
			wdata_q <= 32'h00000000;
			info_q <= 32'h00000000;
			w0_q <= 32'h00000000;
			sar_q <= 32'h00000000;
			dar_q <= 32'h00000000;
			src_q <= 4'h0;
			chained_q <= 1'b0;
			reloaded_q <= 1'b0;
		end
		else if (abort)
		begin
			state_q <= TCACT_IDLE;
			req_q <= 1'b0;
			we_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				TCACT_IDLE:
					if (start)
					begin
						src_q <= pick_idx;
						chained_q <= 1'b0;
						req_q <= 1'b1;
						we_q <= 1'b0;
						if (skip)
						begin
							state_q <= TCACT_RD;
							addr_q <= sar_q;
						end
						else
						begin
							state_q <= TCACT_VEC;
							addr_q <= entry_addr(vbase_q, pick_idx);
						end
					end
				TCACT_VEC:
					if (bus_ack_i)
					begin
						info_q <= {bus_rdata_i[31:2], 2'b00};
						addr_q <= {bus_rdata_i[31:2], 2'b00};
						state_q <= TCACT_INFO0;
					end
				TCACT_INFO0:
					if (bus_ack_i)
					begin
						w0_q <= bus_rdata_i;
						addr_q <= info_q + 32'h00000004;
						state_q <= TCACT_INFO1;
					end
				TCACT_INFO1:
					if (bus_ack_i)
					begin
						sar_q <= bus_rdata_i;
						addr_q <= info_q + 32'h00000008;
						state_q <= TCACT_INFO2;
					end
				TCACT_INFO2:
					if (bus_ack_i)
					begin
						dar_q <= bus_rdata_i;
						addr_q <= sar_q;
						state_q <= TCACT_RD;
					end
				TCACT_RD:
					if (bus_ack_i)
					begin
						we_q <= 1'b1;
						wdata_q <= bus_rdata_i;
						addr_q <= dar_q;
						state_q <= TCACT_WR;
					end
				TCACT_WR:
					if (bus_ack_i)
					begin
						w0_q <= w0_next;
						reloaded_q <= w0_q[TCACT_W0_REPEAT] && low_dec == TCACT_CNT_ZERO;
						wdata_q <= w0_next;
						addr_q <= info_q;
						state_q <= TCACT_WB;
					end
				TCACT_WB:
					if (bus_ack_i)
					begin
						we_q <= 1'b0;
						if (chain_go)
						begin
							chained_q <= 1'b1;
							info_q <= info_q + TCACT_INFO_BYTES;
							addr_q <= info_q + TCACT_INFO_BYTES;
							state_q <= TCACT_INFO0;
						end
						else
						begin
							req_q <= 1'b0;
							state_q <= TCACT_IDLE;
						end
					end
			endcase
		end
	end

	// ==========================================
	// End of activation: source clearing and read skip bookkeeping
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			end_q <= 1'b0;
			flag_clr_q <= 16'h0000;
			last_src_q <= 4'h0;
			last_chain_q <= 1'b0;
			cache_ok_q <= 1'b0;
		end
		else
		begin
			end_q <= 1'b0;
			flag_clr_q <= 16'h0000;
			if (abort || (reg_we_i && reg_addr_i == TCACT_OFS_VBASE))
				cache_ok_q <= 1'b0;
			else if (state_q == TCACT_WB && bus_ack_i && !chain_go)
			begin
				end_q <= 1'b1;
				last_src_q <= src_q;
				last_chain_q <= chained_q;
				cache_ok_q <= 1'b1;
				if (!clr_en)
					flag_clr_q <= 16'h0001 << src_q;
			end
		end
	end

	// ==========================================
	// transfer_control: read skip and chain enables
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			chain_en_q <= TCACT_CTRL_RST[TCACT_CTRL_CHAIN_EN];
			skip_en_q <= TCACT_CTRL_RST[TCACT_CTRL_SKIP_EN];
		end
		else if (reg_we_i && reg_addr_i == TCACT_OFS_CTRL)
		begin
			chain_en_q <= reg_wdata_i[TCACT_CTRL_CHAIN_EN];
			skip_en_q <= reg_wdata_i[TCACT_CTRL_SKIP_EN];
		end
	end

	// Stop flag: a new error wins over a clear in the same cycle
	assign err_clr = reg_we_i && reg_addr_i == TCACT_OFS_CTRL
		&& err_armed_q && !reg_wdata_i[TCACT_CTRL_ERR];
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			err_q <= TCACT_CTRL_RST[TCACT_CTRL_ERR];
			err_armed_q <= 1'b0;
		end
		else
		begin
			if (abort)
				err_q <= 1'b1;
			else if (err_clr)
				err_q <= 1'b0;
			if (reg_re_i && reg_addr_i == TCACT_OFS_CTRL && err_q)
				err_armed_q <= 1'b1;
			else if (err_clr || (reg_we_i && reg_addr_i == TCACT_OFS_CTRL))
				err_armed_q <= 1'b0;
		end
	end

	// ==========================================
	// vector_base and source_enable_bits
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			vbase_q <= TCACT_VB_RST[TCACT_VB_HI:TCACT_VB_LO];
		else if (reg_we_i && reg_addr_i == TCACT_OFS_VBASE)
			vbase_q <= reg_wdata_i[TCACT_VB_HI:TCACT_VB_LO];
	end

	// Hardware clear follows the software write, so the end is never lost
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			src_en_q <= TCACT_SRC_EN_RST;
		else
		begin
			if (state_q == TCACT_WB && bus_ack_i && !chain_go && !abort && clr_en)
				src_en_q <= (reg_we_i && reg_addr_i == TCACT_OFS_SRC_EN ?
					reg_wdata_i[15:0] : src_en_q) & ~(16'h0001 << src_q);
			else if (reg_we_i && reg_addr_i == TCACT_OFS_SRC_EN)
				src_en_q <= reg_wdata_i[15:0];
		end
	end

	// ==========================================
	// Read data, valid only in the cycle after the strobe
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rdata_q <= 32'h00000000;
		else if (reg_re_i)
			unique case (reg_addr_i)
				TCACT_OFS_CTRL: rdata_q <= {27'h0000000, skip_en_q, chain_en_q, 2'b00, err_q};
				TCACT_OFS_VBASE: rdata_q <= {4'h0, vbase_q, 12'h000};
				TCACT_OFS_SRC_EN: rdata_q <= {16'h0000, src_en_q};
				default: rdata_q <= 32'h00000000;
			endcase
		else
			rdata_q <= 32'h00000000;
	end

	assign reg_rdata_o = rdata_q;
	assign cpu_irq_o = cpu_irq_q;
	assign flag_clr_o = flag_clr_q;
	assign bus_req_o = req_q;
	assign bus_we_o = we_q;
	assign bus_addr_o = addr_q;
	assign bus_wdata_o = wdata_q;

	// ==========================================
	// Assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence wb_done_s;
		state_q == TCACT_WB && bus_ack_i && !abort;
	endsequence

	stop_on_nmi_a: assert property (nmi_i |=> err_q && state_q == TCACT_IDLE)
		else $error("stop flag not set after nmi");
	stop_hold_a: assert property (err_q && !err_clr |=> err_q)
		else $error("stop flag dropped without clear");
	ctrl_resv_a: assert property ($past(reg_re_i) |-> reg_rdata_o[2:1] == 2'b00)
		else $error("reserved control bits not zero");
	vb_fixed_a: assert property (reg_rdata_o[31:28] == 4'h0 && reg_rdata_o[11:0] == 12'h000
		|| !$past(reg_re_i && reg_addr_i == TCACT_OFS_VBASE))
		else $error("vector base fixed bits not zero");
	reload_a: assert property (state_q == TCACT_WR && bus_ack_i && !abort
		&& w0_q[TCACT_W0_REPEAT] && low_cnt == TCACT_CNT_ONE |=> low_cnt == $past(hi_cnt))
		else $error("repeat counter not reloaded");
	no_chain_a: assert property (wb_done_s ##0 reloaded_q && !chain_en_q
		|=> state_q == TCACT_IDLE)
		else $error("chain after reload while disabled");
	chain_a: assert property (wb_done_s ##0 reloaded_q && chain_en_q && w0_q[TCACT_W0_CHAIN]
		|=> state_q == TCACT_INFO0)
		else $error("chain missing after reload");
	start_req_a: assert property (state_q == TCACT_IDLE ##1 state_q != TCACT_IDLE
		|-> $past(|(irq_i & src_en_q)))
		else $error("start without enabled request");
	vec_addr_a: assert property ($rose(state_q == TCACT_VEC)
		|-> bus_addr_o == entry_addr(vbase_q, src_q))
		else $error("wrong vector entry address");
	skip_a: assert property (start && skip |=> state_q == TCACT_RD)
		else $error("read skip not taken");
endmodule : tcact_core

// ### design/tcact_pick.sv
// Fixed priority picker over the activation requests
`timescale 1ns/1ns
module tcact_pick
	import tcact_pkg::*;
(
	input wire logic [15:0] req_i,
	output logic valid_o,
	output logic [3:0] idx_o
);
	// ==========================================
	// Highest index wins; later hits override earlier ones
	always_comb
	begin
		valid_o = 1'b0;
		idx_o = 4'h0;
		for (int i = 0; i < TCACT_NSRC; i++)
		begin
			if (req_i[i])
			begin
				valid_o = 1'b1;
				idx_o = 4'(i);
			end
		end
	end
endmodule : tcact_pick

// ### include/tcact_pkg.sv
// Constants, layouts and states shared by the transfer controller activation logic
package tcact_pkg;
	// ==========================================
	// Register map of the plain software port
	localparam logic [3:0] TCACT_OFS_CTRL = 4'h0;
	localparam logic [3:0] TCACT_OFS_VBASE = 4'h4;
	localparam logic [3:0] TCACT_OFS_SRC_EN = 4'h8;
	// ==========================================
	// transfer_control fields
	localparam int TCACT_CTRL_ERR = 0;
	localparam int TCACT_CTRL_CHAIN_EN = 3;
	localparam int TCACT_CTRL_SKIP_EN = 4;
	localparam logic [7:0] TCACT_CTRL_WMASK = 8'h18;
	localparam logic [7:0] TCACT_CTRL_RST = 8'h00;
	// ==========================================
	// vector_base layout: only bits 27 to 12 hold state
	localparam int TCACT_VB_HI = 27;
	localparam int TCACT_VB_LO = 12;
	localparam logic [31:0] TCACT_VB_RST = 32'h00000000;
	localparam logic [15:0] TCACT_SRC_EN_RST = 16'h0000;
	// ==========================================
	// Sources and vector table entries
	localparam int TCACT_NSRC = 16;
	localparam logic [31:0] TCACT_VEC_OFS0 = 32'h00000500;
	localparam logic [31:0] TCACT_ENTRY_BYTES = 32'h00000004;
	localparam logic [31:0] TCACT_INFO_BYTES = 32'h0000000C;
	// ==========================================
	// Transfer information word 0 layout
	localparam int TCACT_W0_REPEAT = 31;
	localparam int TCACT_W0_CHAIN = 30;
	localparam int TCACT_W0_SELECT = 29;
	localparam int TCACT_W0_HI_LSB = 8;
	localparam logic [7:0] TCACT_CNT_ZERO = 8'h00;
	localparam logic [7:0] TCACT_CNT_ONE = 8'h01;
	// ==========================================
	// Sequencer states
	typedef enum logic [3:0] {
		TCACT_IDLE, TCACT_VEC, TCACT_INFO0, TCACT_INFO1, TCACT_INFO2,
		TCACT_RD, TCACT_WR, TCACT_WB
	} tcact_state_t;
endpackage : tcact_pkg

// ### sim/tcact_mem.sv
// Bus memory model standing behind the core's system bus
`timescale 1ns/1ns
module tcact_mem
	import tcact_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [31:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic slow_i,
	input wire logic err_mode_i,
	output logic [31:0] rdata_o,
	output logic ack_o,
	output logic err_o
);
	logic [31:0] mem_q [0:1023];
	logic [1:0] wait_q;
	// ========
	// Answer each access once, slow mode stalls three cycles
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			wait_q <= 2'h0;
			rdata_o <= 32'h00000000;
		end
		else
		begin
			ack_o <= 1'b0;
			err_o <= err_mode_i && req_i;
			rdata_o <= ~rdata_o; // Idle data keeps moving, never a held value
			if (req_i && !ack_o && !err_mode_i)
			begin
				if (slow_i && wait_q != 2'h3)
					wait_q <= wait_q + 2'h1;
				else
				begin
					wait_q <= 2'h0;
					ack_o <= 1'b1;
					if (we_i)
						mem_q[addr_i[11:2]] <= wdata_i;
					else
						rdata_o <= mem_q[addr_i[11:2]];
				end
			end
		end
	end
endmodule : tcact_mem

// ### sim/transfer_ctrl_activation_tb.sv
// Self-checking bench of the transfer controller activation core
`timescale 1ns/1ns
module transfer_ctrl_activation_tb
	import tcact_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] reg_addr_i = 4'h0;
	logic [31:0] reg_wdata_i = 32'h00000000;
	logic reg_we_i = 1'b0;
	logic reg_re_i = 1'b0;
	logic [15:0] irq_i = 16'h0000;
	logic nmi_i = 1'b0;
	logic slow = 1'b0;
	logic err_mode = 1'b0;
	logic re_q = 1'b0;
	logic [31:0] reg_rdata_o, bus_addr_o, bus_wdata_o, bus_rdata_i;
	logic [15:0] cpu_irq_o, flag_clr_o;
	logic [15:0] clr_seen = 16'h0000;
	logic bus_req_o, bus_we_o, bus_ack_i, bus_addr_err_i;
	logic [31:0] exp_q[$];
	logic [31:0] addr_log[$];
	logic [31:0] rnd = 32'h15FB;
	int bad_count = 0;
	int tests_run = 0;
	int acc_n = 0;
	// ========
	// Design and bus partner
	tcact_core u_tcact_core (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
		.reg_rdata_o(reg_rdata_o), .irq_i(irq_i), .nmi_i(nmi_i), .cpu_irq_o(cpu_irq_o),
		.flag_clr_o(flag_clr_o), .bus_req_o(bus_req_o), .bus_we_o(bus_we_o),
		.bus_addr_o(bus_addr_o), .bus_wdata_o(bus_wdata_o), .bus_rdata_i(bus_rdata_i),
		.bus_ack_i(bus_ack_i), .bus_addr_err_i(bus_addr_err_i));
	tcact_mem u_tcact_mem (.clk_i(clk_i), .rst_i(rst_i), .req_i(bus_req_o), .we_i(bus_we_o),
		.addr_i(bus_addr_o), .wdata_i(bus_wdata_o), .slow_i(slow), .err_mode_i(err_mode),
		.rdata_o(bus_rdata_i), .ack_o(bus_ack_i), .err_o(bus_addr_err_i));
	// Free-running clock
	initial
	begin
		forever #2 clk_i = ~clk_i;
	end
	// ========
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {1'b0, x[31:1]} ^ (x[0] ? 32'hA3000000 : 32'h00000000);
	endfunction : lfsr
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize;
		$display("Counts: %0d checks, %0d mismatches", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	// Strobes get a gap cycle so no task lowers and raises one in a step
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
		@(posedge clk_i);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge clk_i);
		reg_re_i <= 1'b0;
		@(posedge clk_i);
	endtask : rd
	task automatic info(input logic [9:0] i, input logic [31:0] w0);
		u_tcact_mem.mem_q[i] = w0;
		u_tcact_mem.mem_q[i + 10'h1] = 32'h00000200;
		u_tcact_mem.mem_q[i + 10'h2] = 32'h00000300;
	endtask : info
	// Raise one request, wait for the expected accesses, then drop it
	task automatic act(input int idx, input int n_acc);
		int t;
		acc_n = 0;
		t = 0;
		clr_seen = 16'h0000;
		addr_log.delete();
		irq_i[idx] <= 1'b1;
		while (acc_n < n_acc && t < 300)
		begin
			@(posedge clk_i);
			t++;
		end
		repeat (6) @(posedge clk_i);
		irq_i[idx] <= 1'b0;
		@(posedge clk_i);
	endtask : act
	// ========
	// Monitor: read data, bus log and the sources dropping on clear
	always @(posedge clk_i)
	begin
		if (re_q)
			check(reg_rdata_o, exp_q.pop_front());
		re_q <= reg_re_i;
		clr_seen <= clr_seen | flag_clr_o;
		if (|flag_clr_o)
			irq_i <= irq_i & ~flag_clr_o;
		if (bus_req_o && bus_ack_i)
		begin
			acc_n++;
			addr_log.push_back(bus_addr_o);
		end
	end
	// Watchdog far beyond the few hundred cycles the tests need
	initial
	begin
		#80000;
		bad_count++;
		summarize();
	end
	// ========
	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(TCACT_OFS_CTRL, 32'h00000000);
		rd(TCACT_OFS_VBASE, 32'h00000000);
		rd(TCACT_OFS_SRC_EN, 32'h00000000);
		wr(TCACT_OFS_CTRL, 32'h000000FF);
		rd(TCACT_OFS_CTRL, 32'h00000018);
		for (int i = 0; i < 4; i++)
		begin
			rnd = lfsr(rnd);
			wr(TCACT_OFS_VBASE, rnd);
			rd(TCACT_OFS_VBASE, rnd & 32'h0FFFF000);
		end
		wr(4'hC, 32'hFFFFFFFF);
		rd(4'hC, 32'h00000000);
		wr(TCACT_OFS_VBASE, 32'h00001000);
		rd(TCACT_OFS_VBASE, 32'h00001000);
		wr(TCACT_OFS_CTRL, 32'h00000000);
		$display("Test registers done");
		irq_i[3] <= 1'b1;
		repeat (2) @(posedge clk_i);
		check({16'h0000, cpu_irq_o}, 32'h00000008);
		irq_i[3] <= 1'b0;
		$display("Test routing done");
		rnd = lfsr(rnd);
		u_tcact_mem.mem_q[10'h140] = 32'h00000100;
		u_tcact_mem.mem_q[10'h141] = 32'h00000180;
		u_tcact_mem.mem_q[10'h080] = rnd;
		info(10'h040, 32'h00000002);
		wr(TCACT_OFS_SRC_EN, 32'h00008000);
		slow <= 1'b1;
		act(15, 7);
		slow <= 1'b0;
		check(acc_n, 7);
		check(addr_log[0], 32'h00001500);
		check(addr_log[1], 32'h00000100);
		check(u_tcact_mem.mem_q[10'h0C0], rnd);
		check(u_tcact_mem.mem_q[10'h040], 32'h00000001);
		check({16'h0000, clr_seen}, 32'h00008000);
		rd(TCACT_OFS_SRC_EN, 32'h00008000);
		wr(TCACT_OFS_CTRL, 32'h00000010);
		act(15, 3);
		check(acc_n, 3);
		check({16'h0000, clr_seen}, 32'h00000000);
		rd(TCACT_OFS_SRC_EN, 32'h00000000);
		$display("Test normal and skip done");
		wr(TCACT_OFS_CTRL, 32'h00000000);
		wr(TCACT_OFS_SRC_EN, 32'h00004000);
		info(10'h060, 32'hC0000301);
		info(10'h063, 32'h00000005);
		act(14, 7);
		check(acc_n, 7);
		check(u_tcact_mem.mem_q[10'h060], 32'hC0000303);
		info(10'h060, 32'hC0000301);
		wr(TCACT_OFS_CTRL, 32'h00000008);
		act(14, 13);
		check(acc_n, 13);
		check(addr_log[7], 32'h0000018C);
		$display("Test repeat and chain done");
		err_mode <= 1'b1;
		irq_i[14] <= 1'b1;
		repeat (8) @(posedge clk_i);
		check({31'h0, bus_req_o}, 32'h00000000);
		irq_i[14] <= 1'b0;
		err_mode <= 1'b0;
		wr(TCACT_OFS_CTRL, 32'h00000000);
		rd(TCACT_OFS_CTRL, 32'h00000001);
		wr(TCACT_OFS_CTRL, 32'h00000001);
		rd(TCACT_OFS_CTRL, 32'h00000001);
		wr(TCACT_OFS_CTRL, 32'h00000000);
		rd(TCACT_OFS_CTRL, 32'h00000000);
		nmi_i <= 1'b1;
		@(posedge clk_i);
		nmi_i <= 1'b0;
		@(posedge clk_i);
		rd(TCACT_OFS_CTRL, 32'h00000001);
		wr(TCACT_OFS_CTRL, 32'h00000000);
		rd(TCACT_OFS_CTRL, 32'h00000000);
		$display("Test stop flag done");
		summarize();
	end
endmodule : transfer_ctrl_activation_tb
